//--- rtl/serial_port_pkg.sv
// Constants and carrier types for the lightweight serial port
`default_nettype none
package serial_port_pkg;
    localparam int REG_W = 18;
    localparam int DATA_BITS = 8;
    localparam int FIFO_DEPTH_DEF = 8;
    localparam int FIFO_DEPTH_MAX = 2048;
    localparam int BAUD_DEF = 115200;
    localparam int BAUD_MIN = 300;
    localparam int BAUD_MAX = 921600;
    localparam int CLK_FREQ_DEF = 25000000;
    // Address map
    localparam logic [17:0] PERIPH_BASE = 18'h1a000;
    localparam logic [17:0] BASE_ADR_DEF = 18'h00010;
    localparam logic [17:0] OFS_STATUS = 18'h00000;
    localparam logic [17:0] OFS_RX_POP = 18'h00001;
    localparam logic [17:0] OFS_TX_PUSH = 18'h00002;
    // Status bit positions
    localparam int BIT_RX_EMPTY = 0;
    localparam int BIT_RX_FULL = 1;
    localparam int BIT_TX_EMPTY = 2;
    localparam int BIT_TX_FULL = 3;
    localparam int BIT_TX_IRQ_PRE = 4;
    localparam int BIT_TX_IRQ_FLAG = 5;
    localparam int BIT_RX_IE = 9;
    localparam int BIT_TX_IE = 10;
    // Values after reset
    localparam logic RST_TX_IRQ_PRE = 1'b1;
    localparam logic RST_TX_IRQ_FLAG = 1'b0;
    localparam logic RST_IE = 1'b0;
    localparam logic RST_LINE = 1'b1;
    localparam logic [17:0] RST_RDATA = 18'h00000;

    typedef struct packed {
        logic [17:0] addr;
        logic [17:0] wdata;
        logic we;
        logic re;
    } bus_req_t;
endpackage
`default_nettype wire

//--- rtl/lightweight_async_serial_port.sv
// Lightweight serial port: FIFO, receiver, transmitter and register access
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Flip-flop FIFO with valid/ready on both sides
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready,
    output logic full,
    output logic empty
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [CW-1:0] count_r;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    // Wrap works for depths that are not powers of two
    function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
        next_ptr = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    assign full = (count_r == CW'(DEPTH));
    assign empty = (count_r == '0);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem_r[rd_ptr_r];

    // Storage is not reset; only pointers matter
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    // Pointer and fill count
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= next_ptr(wr_ptr_r);
            end
            if (pop) begin
                rd_ptr_r <= next_ptr(rd_ptr_r);
            end
            count_r <= count_r + CW'(push) - CW'(pop);
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Top: register access, receiver, transmitter, interrupts
module lightweight_async_serial_port
    import serial_port_pkg::*;
#(
    parameter logic [17:0] BASE_ADR = BASE_ADR_DEF,
    parameter int FIFO_RX_DEPTH = FIFO_DEPTH_DEF,
    parameter int FIFO_TX_DEPTH = FIFO_DEPTH_DEF,
    parameter int BAUDRATE = BAUD_DEF,
    parameter bit INTERRUPT_SUPPORTED = 1'b0,
    parameter int CLOCK_FREQUENCY = CLK_FREQ_DEF
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire bus_req_t bus_req,
    output logic [17:0] bus_rdata,
    input wire logic rx_line,
    output logic tx_line,
    output logic intr_rx,
    output logic intr_tx
);
    // line rate fixed at build time by BAUDRATE
    // bit period from clock and baud, rounded to nearest
    localparam int BIT_DIV = (CLOCK_FREQUENCY + BAUDRATE / 2) / BAUDRATE;
    localparam int HALF_DIV = BIT_DIV / 2;
    localparam int DW = $clog2(BIT_DIV + 1);
    localparam logic [DW-1:0] BIT_LOAD = DW'(BIT_DIV - 1);
    localparam logic [DW-1:0] HALF_LOAD = DW'(HALF_DIV - 1);
    localparam logic [2:0] LAST_BIT = 3'(DATA_BITS - 1);

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // absolute address decode
    // base address taken as offset into peripheral space
    wire [17:0] reg_base = PERIPH_BASE + BASE_ADR;
    wire hit_status = (bus_req.addr == reg_base + OFS_STATUS);
    wire hit_rx = (bus_req.addr == reg_base + OFS_RX_POP);
    wire hit_tx = (bus_req.addr == reg_base + OFS_TX_PUSH);
    wire status_rd = bus_req.re && hit_status;
    wire status_wr = bus_req.we && hit_status;
    wire rx_rd = bus_req.re && hit_rx;
    wire tx_wr = bus_req.we && hit_tx;
    wire any_access = bus_req.re || bus_req.we;

    ////////////////////////////////////////////////////////////////////////////
    // FIFOs
    logic rxf_in_ready, rxf_valid, rxf_full, rxf_empty;
    logic [7:0] rxf_data;
    logic txf_in_ready, txf_valid, txf_full, txf_empty;
    logic [7:0] txf_data;
    logic rx_push;
    logic [7:0] rx_shift_r;
    logic tx_pop;

    // receive shifter feeds the receive FIFO
    // depth from parameter, at most 2048
    byte_fifo #(.WIDTH(DATA_BITS), .DEPTH(FIFO_RX_DEPTH)) rx_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_valid(rx_push),
        .in_data(rx_shift_r),
        .in_ready(rxf_in_ready),
        .out_valid(rxf_valid),
        .out_data(rxf_data),
        .out_ready(rx_rd),
        .full(rxf_full),
        .empty(rxf_empty)
    );

    // depth from parameter, at most 2048
    byte_fifo #(.WIDTH(DATA_BITS), .DEPTH(FIFO_TX_DEPTH)) tx_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_valid(tx_wr),
        .in_data(bus_req.wdata[7:0]),
        .in_ready(txf_in_ready),
        .out_valid(txf_valid),
        .out_data(txf_data),
        .out_ready(tx_pop),
        .full(txf_full),
        .empty(txf_empty)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Receiver: pin passes two flops before use
    logic rx_meta_r, rx_sync_r;
    rx_state_t rx_state_r, rx_state_nxt;
    logic [DW-1:0] rx_cnt_r, rx_cnt_nxt;
    logic [2:0] rx_bit_r, rx_bit_nxt;
    logic [7:0] rx_shift_nxt;
    wire rx_tick = (rx_cnt_r == '0);

    // start bit checked at mid-bit, then eight samples
    // each sample enters from the top, so bit 0 lands first
    // single stop bit, no parity slot
    always_comb begin
        rx_state_nxt = rx_state_r;
        rx_cnt_nxt = rx_tick ? BIT_LOAD : rx_cnt_r - DW'(1);
        rx_bit_nxt = rx_bit_r;
        rx_shift_nxt = rx_shift_r;
        case (rx_state_r)
            RX_IDLE: begin
                rx_cnt_nxt = HALF_LOAD;
                if (!rx_sync_r) begin
                    rx_state_nxt = RX_START;
                end
            end
            RX_START: begin
                if (rx_tick) begin
                    rx_state_nxt = rx_sync_r ? RX_IDLE : RX_DATA;
                    rx_bit_nxt = '0;
                end
            end
            RX_DATA: begin
                if (rx_tick) begin
                    rx_shift_nxt = {rx_sync_r, rx_shift_r[7:1]};
                    rx_bit_nxt = rx_bit_r + 3'd1;
                    if (rx_bit_r == LAST_BIT) begin
                        rx_state_nxt = RX_STOP;
                    end
                end
            end
            RX_STOP: begin
                if (rx_tick) begin
                    rx_state_nxt = RX_IDLE;
                end
            end
            default: rx_state_nxt = RX_IDLE;
        endcase
    end

    // Frames with a low stop bit are dropped; a full FIFO also drops
    assign rx_push = (rx_state_r == RX_STOP) && rx_tick && rx_sync_r && rxf_in_ready;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_meta_r <= RST_LINE;
            rx_sync_r <= RST_LINE;
            rx_state_r <= RX_IDLE;
            rx_cnt_r <= '0;
            rx_bit_r <= '0;
            rx_shift_r <= '0;
        end else begin
            rx_meta_r <= rx_line;
            rx_sync_r <= rx_meta_r;
            rx_state_r <= rx_state_nxt;
            rx_cnt_r <= rx_cnt_nxt;
            rx_bit_r <= rx_bit_nxt;
            rx_shift_r <= rx_shift_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmitter; the FIFO stalls while a frame is on the line
    tx_state_t tx_state_r, tx_state_nxt;
    logic [DW-1:0] tx_cnt_r, tx_cnt_nxt;
    logic [2:0] tx_bit_r, tx_bit_nxt;
    logic [7:0] tx_shift_r, tx_shift_nxt;
    logic tx_line_r, tx_line_nxt;
    logic tx_done;
    wire tx_tick = (tx_cnt_r == '0);
    assign tx_pop = (tx_state_r == TX_IDLE) && txf_valid;

    // start bit low, then eight data bits
    // shift right, bit 0 goes out first
    // idle high, stop bit high for a full period
    always_comb begin
        tx_state_nxt = tx_state_r;
        tx_cnt_nxt = tx_tick ? BIT_LOAD : tx_cnt_r - DW'(1);
        tx_bit_nxt = tx_bit_r;
        tx_shift_nxt = tx_shift_r;
        tx_line_nxt = tx_line_r;
        tx_done = 1'b0;
        case (tx_state_r)
            TX_IDLE: begin
                tx_line_nxt = RST_LINE;
                tx_cnt_nxt = BIT_LOAD;
                if (txf_valid) begin
                    tx_state_nxt = TX_START;
                    tx_shift_nxt = txf_data;
                    tx_line_nxt = 1'b0;
                end
            end
            TX_START: begin
                if (tx_tick) begin
                    tx_state_nxt = TX_DATA;
                    tx_bit_nxt = '0;
                    tx_line_nxt = tx_shift_r[0];
                end
            end
            TX_DATA: begin
                if (tx_tick) begin
                    tx_bit_nxt = tx_bit_r + 3'd1;
                    tx_shift_nxt = {1'b0, tx_shift_r[7:1]};
                    tx_line_nxt = tx_shift_r[1];
                    if (tx_bit_r == LAST_BIT) begin
                        tx_state_nxt = TX_STOP;
                        tx_line_nxt = 1'b1;
                    end
                end
            end
            TX_STOP: begin
                if (tx_tick) begin
                    tx_state_nxt = TX_IDLE;
                    tx_done = 1'b1;
                end
            end
            default: tx_state_nxt = TX_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tx_state_r <= TX_IDLE;
            tx_cnt_r <= '0;
            tx_bit_r <= '0;
            tx_shift_r <= '0;
            tx_line_r <= RST_LINE;
        end else begin
            tx_state_r <= tx_state_nxt;
            tx_cnt_r <= tx_cnt_nxt;
            tx_bit_r <= tx_bit_nxt;
            tx_shift_r <= tx_shift_nxt;
            tx_line_r <= tx_line_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status flags and interrupt state; set always beats clear
    logic tx_pre_r, tx_flag_r, rx_ie_r, tx_ie_r;
    logic last_tx_wr_r, rx_pend_r, tx_pend_r;
    logic intr_rx_r, intr_tx_r;
    logic [17:0] rdata_r;

    // set by any data write, even one dropped at a full FIFO, cleared by the shifter's pop
    wire tx_pre_nxt = tx_wr || (tx_pre_r && !tx_pop);
    // set when a frame finishes, cleared by status write
    wire tx_flag_nxt = tx_done || (tx_flag_r && !status_wr);
    // last access was a data write, FIFO not full
    wire last_tx_wr_nxt = any_access ? tx_wr : last_tx_wr_r;
    wire tx_pend_nxt = (tx_done && last_tx_wr_r && !txf_full) || (tx_pend_r && !status_rd && !status_wr);
    // first frame into an empty FIFO
    wire rx_pend_nxt = (rx_push && rxf_empty) || (rx_pend_r && !rx_rd);
    // enables exist only with interrupt support
    wire rx_ie_nxt = INTERRUPT_SUPPORTED && (status_wr ? bus_req.wdata[BIT_RX_IE] : rx_ie_r);
    wire tx_ie_nxt = INTERRUPT_SUPPORTED && (status_wr ? bus_req.wdata[BIT_TX_IE] : tx_ie_r);

    logic [17:0] status_word;
    always_comb begin
        status_word = '0;
        status_word[BIT_RX_EMPTY] = rxf_empty;
        status_word[BIT_RX_FULL] = rxf_full;
        status_word[BIT_TX_EMPTY] = txf_empty;
        status_word[BIT_TX_FULL] = txf_full;
        status_word[BIT_TX_IRQ_PRE] = tx_pre_r;
        status_word[BIT_TX_IRQ_FLAG] = tx_flag_r;
        status_word[BIT_RX_IE] = rx_ie_r;
        status_word[BIT_TX_IE] = tx_ie_r;
    end

    // oldest byte in bits 7..0, upper bits zero
    wire [17:0] rx_word = {10'h000, rxf_data};
    wire [17:0] rdata_nxt = hit_status ? status_word : (hit_rx ? rx_word : 18'h00000);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tx_pre_r <= RST_TX_IRQ_PRE;
            tx_flag_r <= RST_TX_IRQ_FLAG;
            rx_ie_r <= RST_IE;
            tx_ie_r <= RST_IE;
            last_tx_wr_r <= 1'b0;
            tx_pend_r <= 1'b0;
            rx_pend_r <= 1'b0;
            intr_rx_r <= 1'b0;
            intr_tx_r <= 1'b0;
            rdata_r <= RST_RDATA;
        end else begin
            tx_pre_r <= tx_pre_nxt;
            tx_flag_r <= tx_flag_nxt;
            rx_ie_r <= rx_ie_nxt;
            tx_ie_r <= tx_ie_nxt;
            last_tx_wr_r <= last_tx_wr_nxt;
            tx_pend_r <= tx_pend_nxt;
            rx_pend_r <= rx_pend_nxt;
            intr_rx_r <= INTERRUPT_SUPPORTED && rx_pend_nxt && rx_ie_nxt;
            intr_tx_r <= INTERRUPT_SUPPORTED && tx_pend_nxt && tx_ie_nxt;
            if (bus_req.re) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    assign bus_rdata = rdata_r;
    assign tx_line = tx_line_r;
    assign intr_rx = intr_rx_r;
    assign intr_tx = intr_tx_r;
endmodule

`default_nettype wire

//--- testbench/serial_port_chk.sv
// Port-level assertion checker for the serial port
`timescale 1ns/1ns
`default_nettype none
module serial_port_chk
    import serial_port_pkg::*;
#(
    parameter logic [17:0] BASE_ADR = BASE_ADR_DEF,
    parameter int BAUDRATE = BAUD_DEF,
    parameter int CLOCK_FREQUENCY = CLK_FREQ_DEF
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire bus_req_t bus_req,
    input wire logic [17:0] bus_rdata,
    input wire logic rx_line,
    input wire logic tx_line,
    input wire logic intr_rx,
    input wire logic intr_tx
);
    localparam int BIT_DIV = (CLOCK_FREQUENCY + BAUDRATE / 2) / BAUDRATE;
    localparam logic [17:0] A_ST = PERIPH_BASE + BASE_ADR + OFS_STATUS;
    localparam logic [17:0] A_RX = PERIPH_BASE + BASE_ADR + OFS_RX_POP;
    logic [15:0] low_run_r;
    logic [1:0] ie_r;
    logic st_acc;
    logic st_rd;
    logic rx_rd;
    logic odd_rd;

    // Access decode seen from the bus
    assign st_acc = (bus_req.we || bus_req.re) && bus_req.addr == A_ST;
    assign st_rd = bus_req.re && bus_req.addr == A_ST;
    assign rx_rd = bus_req.re && bus_req.addr == A_RX;
    assign odd_rd = bus_req.re && bus_req.addr != A_ST && bus_req.addr != A_RX;

    ////////////////////////////////////////
    // Low stretch length and shadow of the enables; reads lag, so both edges matter
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            low_run_r <= 16'h0000;
            ie_r <= 2'b00;
        end else begin
            low_run_r <= tx_line ? 16'h0000 : low_run_r + 16'h0001;
            ie_r <= (bus_req.we && bus_req.addr == A_ST) ? bus_req.wdata[10:9] : ie_r;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    AST_LOW_WHOLE_BITS: assert property (tx_line && low_run_r != 0 |-> low_run_r % BIT_DIV == 0)
        else $error("low stretch not whole bits");
    AST_LOW_MAX_NINE: assert property (tx_line |-> low_run_r <= 9 * BIT_DIV)
        else $error("low stretch too long");
    AST_HIGH_BIT_HOLDS: assert property ($rose(tx_line) && low_run_r != 0 |-> tx_line[*8])
        else $error("high bit too short");
    AST_IDLE_IN_RESET: assert property (disable iff (1'b0) rst |-> tx_line)
        else $error("line not idle in reset");
    AST_RX_UPPER_ZERO: assert property (rx_rd |-> ##2 bus_rdata[17:8] == 10'h000)
        else $error("rx upper bits set");
    AST_UNMAPPED_ZERO: assert property (odd_rd |-> ##2 bus_rdata == 18'h00000)
        else $error("unmapped read not zero");
    AST_STATUS_SPARE: assert property (st_rd |-> ##2 bus_rdata[17:11] == 7'h00 && bus_rdata[8:6] == 3'h0)
        else $error("status spare bits set");
    AST_RX_IRQ_GATED: assert property (intr_rx |-> ie_r[0] || $past(ie_r[0]))
        else $error("rx irq without enable");
    AST_TX_IRQ_GATED: assert property (intr_tx |-> ie_r[1] || $past(ie_r[1]))
        else $error("tx irq without enable");
    AST_TX_IRQ_CLEAR: assert property (st_acc |-> ##2 !intr_tx)
        else $error("tx irq not cleared");
    AST_RX_IRQ_CLEAR: assert property (rx_rd |-> ##2 !intr_rx)
        else $error("rx irq not cleared");

    cover property ($rose(tx_line) && low_run_r != 0);
    cover property ($rose(intr_rx));
    cover property ($rose(intr_tx));
endmodule

bind lightweight_async_serial_port serial_port_chk #(.BASE_ADR(BASE_ADR), .BAUDRATE(BAUDRATE),
    .CLOCK_FREQUENCY(CLOCK_FREQUENCY)) i_serial_port_chk (.clk_sys(clk_sys), .rst(rst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .rx_line(rx_line), .tx_line(tx_line), .intr_rx(intr_rx), .intr_tx(intr_tx));
`default_nettype wire

//--- testbench/serial_peer_model.sv
// Far-side serial peer: frame sender and frame catcher
`timescale 1ns/1ns
`default_nettype none
module serial_peer_model #(
    parameter int BIT_DIV = 14
) (
    input wire logic clk_sys,
    input wire logic tx_line,
    output logic rx_line
);
    logic [7:0] got[$];
    int bad_stop = 0;

    initial rx_line = 1'b1;

    ////////////////////////////////////////
    // low start, eight bits LSB first, one stop (low only on purpose)
    task automatic send(input logic [7:0] d, input logic stop);
        logic [9:0] f;
        f = {stop, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_sys);
            rx_line <= f[i];
            repeat (BIT_DIV - 1) @(posedge clk_sys);
        end
        @(posedge clk_sys);
        rx_line <= 1'b1;
    endtask

    // sample each bit mid-way, stop must be high
    initial begin
        logic [7:0] d;
        forever begin
            @(posedge clk_sys);
            if (tx_line === 1'b0) begin
                repeat (BIT_DIV / 2) @(posedge clk_sys);
                for (int i = 0; i < 8; i++) begin
                    repeat (BIT_DIV) @(posedge clk_sys);
                    d[i] = tx_line;
                end
                repeat (BIT_DIV) @(posedge clk_sys);
                if (tx_line !== 1'b1) bad_stop++;
                got.push_back(d);
            end
        end
    end
endmodule
`default_nettype wire

//--- testbench/lightweight_async_serial_port_tb_top.sv
// Self-checking bench for the lightweight serial port
`timescale 1ns/1ns
`default_nettype none
module lightweight_async_serial_port_tb_top
    import serial_port_pkg::*;
;
    // Small clock figure keeps each bit at 14 cycles
    localparam int CLK_HZ = 1600000;
    localparam int BIT_DIV = (CLK_HZ + BAUD_DEF / 2) / BAUD_DEF;
    logic clk_sys;
    logic rst;
    bus_req_t bus_req;
    logic [17:0] bus_rdata;
    logic rx_line, tx_line, intr_rx, intr_tx;
    int miscompares = 0;
    int check_count = 0;

    lightweight_async_serial_port #(.INTERRUPT_SUPPORTED(1'b1), .CLOCK_FREQUENCY(CLK_HZ))
        i_lightweight_async_serial_port (.clk_sys(clk_sys), .rst(rst), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .rx_line(rx_line), .tx_line(tx_line), .intr_rx(intr_rx), .intr_tx(intr_tx));
    serial_peer_model #(.BIT_DIV(BIT_DIV)) i_serial_peer_model (.clk_sys(clk_sys), .tx_line(tx_line),
        .rx_line(rx_line));

    // 125 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////
    task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // Write strobe held for exactly one taking edge
    task automatic wr(input logic [17:0] ofs, input logic [17:0] d);
        @(posedge clk_sys);
        bus_req <= '{addr: PERIPH_BASE + BASE_ADR_DEF + ofs, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge clk_sys);
        bus_req.we <= 1'b0;
    endtask

    // Read data lands after the taking edge and then holds
    task automatic rchk(input logic [17:0] ofs, input logic [17:0] exp);
        @(posedge clk_sys);
        bus_req <= '{addr: PERIPH_BASE + BASE_ADR_DEF + ofs, wdata: 18'h00000, we: 1'b0, re: 1'b1};
        @(posedge clk_sys);
        bus_req.re <= 1'b0;
        @(posedge clk_sys);
        #1 chk(bus_rdata, exp);
    endtask

    // Wait for n caught frames, bounded, then let the stop bit finish
    task automatic wait_tx(input int n);
        int t = 0;
        while (i_serial_peer_model.got.size() < n && t < 3000) begin
            @(posedge clk_sys);
            t++;
        end
        // A frame that never arrives is a failure, not a silent skip
        if (t >= 3000) begin
            miscompares++;
            $display("Error at %0t: frame wait timed out", $time);
        end
        repeat (BIT_DIV) @(posedge clk_sys);
    endtask

    task automatic pchk(input int i, input logic [7:0] e);
        chk({10'h000, i_serial_peer_model.got[i]}, {10'h000, e});
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the few thousand cycles the tests need
    initial begin
        repeat (40000) @(posedge clk_sys);
        miscompares++;
        test_done;
    end

    ////////////////////////////////////////
    initial begin
        bus_req = '0;
        rst = 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        rchk(OFS_STATUS, 18'h00015);
        rchk(18'h00003, 18'h00000);
        rchk(OFS_TX_PUSH, 18'h00000);
        $display("test reset done");
        wr(OFS_TX_PUSH, 18'h3ffa5);
        wait_tx(1);
        pchk(0, 8'ha5);
        rchk(OFS_STATUS, 18'h00025);
        wr(OFS_STATUS, 18'h00000);
        rchk(OFS_STATUS, 18'h00005);
        $display("test single send done");
        for (int i = 0; i < 9; i++) wr(OFS_TX_PUSH, {10'h000, 4'h3, 4'(i)});
        rchk(OFS_STATUS, 18'h00019);
        wr(OFS_TX_PUSH, 18'h000ff);
        wait_tx(10);
        for (int i = 0; i < 9; i++) pchk(i + 1, {4'h3, 4'(i)});
        rchk(OFS_STATUS, 18'h00025);
        wr(OFS_STATUS, 18'h00000);
        $display("test send fill done");
        i_serial_peer_model.send(8'h99, 1'b0);
        rchk(OFS_STATUS, 18'h00005);
        for (int i = 0; i < 9; i++) i_serial_peer_model.send({4'h5, 4'(i)}, 1'b1);
        repeat (4) @(posedge clk_sys);
        rchk(OFS_STATUS, 18'h00006);
        for (int i = 0; i < 8; i++) rchk(OFS_RX_POP, {10'h000, 4'h5, 4'(i)});
        rchk(OFS_STATUS, 18'h00005);
        $display("test receive done");
        wr(OFS_STATUS, 18'h00600);
        rchk(OFS_STATUS, 18'h00605);
        i_serial_peer_model.send(8'h6e, 1'b1);
        repeat (4) @(posedge clk_sys);
        chk({17'h00000, intr_rx}, 18'h00001);
        rchk(OFS_RX_POP, 18'h0006e);
        chk({17'h00000, intr_rx}, 18'h00000);
        wr(OFS_TX_PUSH, 18'h00081);
        wait_tx(11);
        chk({17'h00000, intr_tx}, 18'h00001);
        rchk(OFS_STATUS, 18'h00625);
        chk({17'h00000, intr_tx}, 18'h00000);
        wr(OFS_TX_PUSH, 18'h00042);
        wait_tx(12);
        chk({17'h00000, intr_tx}, 18'h00001);
        wr(OFS_STATUS, 18'h00600);
        repeat (2) @(posedge clk_sys);
        chk({17'h00000, intr_tx}, 18'h00000);
        wr(OFS_STATUS, 18'h00000);
        i_serial_peer_model.send(8'h11, 1'b1);
        repeat (4) @(posedge clk_sys);
        chk({17'h00000, intr_rx}, 18'h00000);
        rchk(OFS_RX_POP, 18'h00011);
        pchk(10, 8'h81);
        pchk(11, 8'h42);
        chk(18'(i_serial_peer_model.got.size()), 18'h0000c);
        chk(18'(i_serial_peer_model.bad_stop), 18'h00000);
        $display("test interrupts done");
        test_done;
    end
endmodule
`default_nettype wire
